// ### synth_pkg.sv
// Purpose: shared constants and types for the synthesizer control block
// Assumes: 16-bit serial words, 4-bit address on top, 12 data bits below
// Notes:   register indices and config bit positions live here only
package synth_pkg;

  localparam int WORD_W   = 16;
  localparam int ADDR_W   = 4;
  localparam int NUM_REGS = 10;
  localparam int REF_W    = 5;
  localparam int NREG_W   = 9;
  localparam int DIVV_W   = 10;
  localparam int FRAC_W   = 18;
  localparam int SHORT_W  = 10;
  localparam int LSB_W    = 8;
  localparam int GAIN_W   = 5;
  localparam int PWR_W    = 4;
  localparam int CNT_W    = 5;
  localparam int LOCK_W   = 4;
  localparam int ADDR_LSB = 12;

  // divider offset and dither bounds
  localparam logic [DIVV_W-1:0]       DIV_OFFSET = 10'h020;
  localparam logic signed [FRAC_W+1:0] FRAC_HALF = 20'sh20000;
  localparam logic signed [FRAC_W+1:0] FRAC_FULL = 20'sh40000;

  // frames shorter than this many edges are modulation samples
  localparam logic [CNT_W-1:0] MOD_EDGES = 5'h0d;
  localparam logic [CNT_W-1:0] CNT_MAX   = 5'h1f;

  // lock window on the reference/vco tick difference
  localparam logic signed [LOCK_W-1:0] LOCK_TOL = 4'sh1;
  localparam logic signed [LOCK_W-1:0] LOCK_MAX = 4'sh7;
  localparam logic signed [LOCK_W-1:0] LOCK_MIN = -4'sh7;

  // register indices
  localparam logic [ADDR_W-1:0] REG_MAIN_DIV = 4'h0;
  localparam logic [ADDR_W-1:0] REG_MAIN_MSB = 4'h1;
  localparam logic [ADDR_W-1:0] REG_MAIN_LSB = 4'h2;
  localparam logic [ADDR_W-1:0] REG_AUX_DIV  = 4'h3;
  localparam logic [ADDR_W-1:0] REG_AUX_DVD  = 4'h4;
  localparam logic [ADDR_W-1:0] REG_REF_DIV  = 4'h5;
  localparam logic [ADDR_W-1:0] REG_CP_GAIN  = 4'h6;
  localparam logic [ADDR_W-1:0] REG_PWR      = 4'h7;
  localparam logic [ADDR_W-1:0] REG_CONFIG   = 4'h8;
  localparam logic [ADDR_W-1:0] REG_MOD      = 4'h9;

  // field positions
  localparam int REF_MAIN_LSB  = 0;
  localparam int REF_AUX_LSB   = 5;
  localparam int GAIN_MAIN_LSB = 0;
  localparam int GAIN_AUX_LSB  = 5;
  localparam int CFG_MAIN_FRAC = 0;
  localparam int CFG_MAIN_18   = 1;
  localparam int CFG_AUX_FRAC  = 2;
  localparam int CFG_STEER     = 3;
  localparam int CFG_MUX_LSB   = 4;

  // values after reset
  localparam logic [WORD_W-1:0] REG_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] CFG_RESET = 16'h0005;

  typedef enum logic [1:0] {MUX_LOW, MUX_LOOP, MUX_LOCK, MUX_REF} mux_sel_t;

  // rising edge of a synchronised level
  function automatic logic rise(input logic prev, input logic cur);
    rise = cur & ~prev;
  endfunction : rise

endpackage : synth_pkg

// ### frac_if.sv
// Purpose: carries divider settings into a fractional unit and back
// Assumes: step is a one-cycle pulse at each vco divider terminal count
// Notes:   two instances per synthesizer, one for main and one for aux
`timescale 1ns/1ps
interface frac_if;
  import synth_pkg::*;
  logic [NREG_W-1:0]        nreg;
  logic signed [FRAC_W-1:0] dividend;
  logic                     frac_en;
  logic                     step;
  logic [DIVV_W-1:0]        div_val;
  modport ctrl (output nreg, dividend, frac_en, step, input div_val);
  modport unit (input nreg, dividend, frac_en, step, output div_val);
endinterface : frac_if

// ### frac_unit.sv
// Purpose: delta-sigma dither of the vco division value
// Assumes: dividend is signed, already scaled to FRAC_W bits
// Notes:   first-order error feedback, dither of -1, 0 or +1
`timescale 1ns/1ps
module frac_unit
  import synth_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rstn,
  // settings and result
  frac_if.unit      fi
);

  logic signed [FRAC_W+1:0] res_q;
  logic signed [FRAC_W+1:0] sum;
  logic signed [FRAC_W+1:0] res_d;
  logic                     up;
  logic                     dn;
  logic [DIVV_W-1:0]        base;
  logic [DIVV_W-1:0]        div_d;

  // residue plus new fraction, folded back into range
  assign sum   = res_q + {{2{fi.dividend[FRAC_W-1]}}, fi.dividend};
  assign up    = fi.frac_en & (sum >= FRAC_HALF);
  assign dn    = fi.frac_en & (sum < -FRAC_HALF);
  assign res_d = up ? sum - FRAC_FULL : (dn ? sum + FRAC_FULL : sum);
  assign base  = {1'b0, fi.nreg} + DIV_OFFSET;
  // integer setting plus dither
  assign div_d = up ? base + 10'h001 : (dn ? base - 10'h001 : base);

  // advance once per vco divider terminal count
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      res_q      <= '0;
      fi.div_val <= DIV_OFFSET;
    end
    else if (fi.step)
    begin
      res_q      <= fi.frac_en ? res_d : '0;
      fi.div_val <= div_d;
    end
  end

endmodule : frac_unit

// ### ref_divider.sv
// Purpose: divides the crystal clock by code plus one
// Assumes: runs on the crystal-derived clock
// Notes:   a new code is taken only at terminal count
`timescale 1ns/1ps
module ref_divider
  import synth_pkg::*;
#(
  parameter int W = REF_W
)
(
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  // ratio code and divided tick
  input  wire logic [W-1:0] code,
  output logic              tick
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] code_q;
  logic         tc;

  assign tc = (cnt_q == code_q);

  // count 0..code, reload code at wrap
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      cnt_q  <= '0;
      code_q <= '0;
      tick   <= 1'b0;
    end
    else
    begin
      cnt_q  <= tc ? '0 : cnt_q + 1'b1;
      code_q <= tc ? code : code_q;
      tick   <= tc;
    end
  end

endmodule : ref_divider

// ### synth_ctrl.sv
// Purpose: digital control of a dual fractional-N synthesizer
// Assumes: serial port and vco inputs are asynchronous to ref_clk
// Notes:   serial clock must be well below ref_clk/3 to be sampled
`timescale 1ns/1ps

module synth_ctrl
  import synth_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  // serial programming port
  input  wire logic              sclk,
  input  wire logic              sdata,
  input  wire logic              cs_n,
  output logic                   mux_out,
  // prescaled vco inputs
  input  wire logic              main_vco_in,
  input  wire logic              aux_vco_in,
  // shared lock or steer pin, open-drain in lock mode, driven both ways in steer mode
  input  wire logic              lock_or_steer_output_i,
  output logic                   lock_or_steer_output_o,
  output logic                   lock_or_steer_output_oe,
  // phase detector side
  output logic                   main_ref_tick,
  output logic                   aux_ref_tick,
  output logic                   main_vco_tick,
  output logic                   aux_vco_tick,
  output logic [GAIN_W-1:0]      main_phase_detector_gain,
  output logic [GAIN_W-1:0]      aux_phase_detector_gain,
  output logic                   steer_up,
  output logic                   steer_dn,
  output logic                   main_locked,
  // power and modulation
  output logic [PWR_W-1:0]       power_down,
  output logic [WORD_W-1:0]      mod_data,
  output logic [DIVV_W-1:0]      main_div_now,
  output logic [DIVV_W-1:0]      aux_div_now
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  logic [2:0] sclk_q;
  logic [1:0] sdata_q;
  logic [2:0] cs_q;
  logic [2:0] mvco_q;
  logic [2:0] avco_q;
  logic [1:0] pin_q;

  // two stages before any logic, third for edges
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      sclk_q  <= '0;
      sdata_q <= '0;
      cs_q    <= 3'h7;
      mvco_q  <= '0;
      avco_q  <= '0;
      pin_q   <= 2'h3;
    end
    else
    begin
      sclk_q  <= {sclk_q[1:0], sclk};
      sdata_q <= {sdata_q[0], sdata};
      cs_q    <= {cs_q[1:0], cs_n};
      mvco_q  <= {mvco_q[1:0], main_vco_in};
      avco_q  <= {avco_q[1:0], aux_vco_in};
      pin_q   <= {pin_q[0], lock_or_steer_output_i};
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic selected;
  logic frame_end;
  logic mvco_rise;
  logic avco_rise;

  // edges seen only on the second and third stages
  assign sclk_rise = rise(sclk_q[2], sclk_q[1]);
  assign sclk_fall = rise(sclk_q[1], sclk_q[2]);
  assign selected  = ~cs_q[1];
  assign frame_end = rise(cs_q[2], cs_q[1]);
  assign mvco_rise = rise(mvco_q[2], mvco_q[1]);
  assign avco_rise = rise(avco_q[2], avco_q[1]);

  ////////////////////////////////////////////////////////////////////////////
  // serial shift register and frame decode

  logic [WORD_W-1:0] shift_q;
  logic [CNT_W-1:0]  edges_q;
  logic              loop_bit_q;

  // shift on rising sclk, loop back on falling
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      shift_q    <= '0;
      edges_q    <= '0;
      loop_bit_q <= 1'b0;
    end
    else if (!selected)
    begin
      shift_q <= '0;
      edges_q <= '0;
    end
    else
    begin
      if (sclk_rise)
      begin
        shift_q <= {shift_q[WORD_W-2:0], sdata_q[1]};
        edges_q <= (edges_q == CNT_MAX) ? CNT_MAX : edges_q + 1'b1;
      end
      if (sclk_fall)
        loop_bit_q <= shift_q[0];
    end
  end

  logic              frame_has_bits;
  logic              is_mod;
  logic [ADDR_W-1:0] frame_addr;
  logic              wr_en;
  logic [WORD_W-1:0] wr_data;

  // long frames carry an address, short ones are samples
  assign frame_has_bits = (edges_q != '0);
  assign is_mod     = frame_has_bits & (edges_q < MOD_EDGES);
  assign frame_addr = is_mod ? REG_MOD : shift_q[WORD_W-1:ADDR_LSB];
  assign wr_en      = frame_end & frame_has_bits &
                      (frame_addr < ADDR_W'(NUM_REGS));
  assign wr_data    = is_mod ? shift_q
                             : {{ADDR_W{1'b0}}, shift_q[ADDR_LSB-1:0]};

  ////////////////////////////////////////////////////////////////////////////
  // register file

  logic [WORD_W-1:0] regs_q [NUM_REGS];

  // one word per index, config has its own reset value
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        regs_q[i] <= REG_RESET;
      regs_q[REG_CONFIG] <= CFG_RESET;
    end
    else if (wr_en)
      regs_q[frame_addr] <= wr_data;
  end

  logic              main_frac;
  logic              main_18;
  logic              aux_frac;
  logic              steer_mode;
  mux_sel_t          mux_sel;

  // configuration fields
  assign main_frac  = regs_q[REG_CONFIG][CFG_MAIN_FRAC];
  assign main_18    = regs_q[REG_CONFIG][CFG_MAIN_18];
  assign aux_frac   = regs_q[REG_CONFIG][CFG_AUX_FRAC];
  assign steer_mode = regs_q[REG_CONFIG][CFG_STEER];
  assign mux_sel    = mux_sel_t'(regs_q[REG_CONFIG][CFG_MUX_LSB +: 2]);

  ////////////////////////////////////////////////////////////////////////////
  // ratio apply in loading order

  logic apply_main_q;
  logic apply_aux_q;
  logic main_trig;
  logic aux_trig;

  // last register of the order makes the ratio live
  assign main_trig = wr_en & (frame_addr ==
                     (main_frac ? REG_MAIN_MSB : REG_MAIN_DIV));
  assign aux_trig  = wr_en & (frame_addr ==
                     (aux_frac ? REG_AUX_DVD : REG_AUX_DIV));

  logic [NREG_W-1:0]        main_nreg_q;
  logic [NREG_W-1:0]        aux_nreg_q;
  logic signed [FRAC_W-1:0] main_dvd_q;
  logic signed [FRAC_W-1:0] aux_dvd_q;
  logic signed [FRAC_W-1:0] main_dvd_new;
  logic signed [FRAC_W-1:0] aux_dvd_new;
  logic [LSB_W-1:0]         main_lsb;

  // 10-bit words sit in the upper bits of the 18-bit path
  assign main_lsb     = main_18 ? regs_q[REG_MAIN_LSB][LSB_W-1:0]
                                : '0;
  assign main_dvd_new = {regs_q[REG_MAIN_MSB][SHORT_W-1:0], main_lsb};
  assign aux_dvd_new  = {regs_q[REG_AUX_DVD][SHORT_W-1:0],
                         {LSB_W{1'b0}}};

  // copy settings one cycle after the triggering write
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      apply_main_q <= 1'b0;
      apply_aux_q  <= 1'b0;
      main_nreg_q  <= '0;
      aux_nreg_q   <= '0;
      main_dvd_q   <= '0;
      aux_dvd_q    <= '0;
    end
    else
    begin
      apply_main_q <= main_trig;
      apply_aux_q  <= aux_trig;
      if (apply_main_q)
      begin
        main_nreg_q <= regs_q[REG_MAIN_DIV][NREG_W-1:0];
        main_dvd_q  <= main_dvd_new;
      end
      if (apply_aux_q)
      begin
        aux_nreg_q <= regs_q[REG_AUX_DIV][NREG_W-1:0];
        aux_dvd_q  <= aux_dvd_new;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference dividers

  logic mref_tick;
  logic aref_tick;

  ref_divider #(.W(REF_W)) u_main_ref (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .code    (regs_q[REG_REF_DIV][REF_MAIN_LSB +: REF_W]),
    .tick    (mref_tick)
  );

  ref_divider #(.W(REF_W)) u_aux_ref (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .code    (regs_q[REG_REF_DIV][REF_AUX_LSB +: REF_W]),
    .tick    (aref_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // vco dividers with fractional units

  frac_if main_fi ();
  frac_if aux_fi ();

  logic [DIVV_W-1:0] mcnt_q;
  logic [DIVV_W-1:0] acnt_q;
  logic              mtc;
  logic              atc;

  assign mtc = mvco_rise & (mcnt_q >= main_fi.div_val - 10'h001);
  assign atc = avco_rise & (acnt_q >= aux_fi.div_val - 10'h001);

  assign main_fi.nreg     = main_nreg_q;
  assign main_fi.dividend = main_dvd_q;
  assign main_fi.frac_en  = main_frac;
  assign main_fi.step     = mtc;
  assign aux_fi.nreg      = aux_nreg_q;
  assign aux_fi.dividend  = aux_dvd_q;
  assign aux_fi.frac_en   = aux_frac;
  assign aux_fi.step      = atc;

  frac_unit u_main_frac (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .fi      (main_fi.unit)
  );

  frac_unit u_aux_frac (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .fi      (aux_fi.unit)
  );

  // count vco edges up to the current division value
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      mcnt_q <= '0;
      acnt_q <= '0;
    end
    else
    begin
      if (mvco_rise)
        mcnt_q <= mtc ? '0 : mcnt_q + 10'h001;
      if (avco_rise)
        acnt_q <= atc ? '0 : acnt_q + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lock detect and frequency steering

  logic signed [LOCK_W-1:0] diff_q;
  logic signed [LOCK_W:0]   diff_d;
  logic                     locked;
  logic                     vco_fast;

  // reference ticks count up, vco ticks count down
  assign diff_d   = $signed({diff_q[LOCK_W-1], diff_q}) // spare bit
                  + (mref_tick ? 5'sh01 : 5'sh00)
                  - (mtc ? 5'sh01 : 5'sh00);
  assign locked   = (diff_q <= LOCK_TOL) & (diff_q >= -LOCK_TOL);
  assign vco_fast = (diff_q < 4'sh0);

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      diff_q <= '0;
    else if (diff_d > LOCK_MAX)
      diff_q <= LOCK_MAX;
    else if (diff_d < LOCK_MIN)
      diff_q <= LOCK_MIN;
    else
      diff_q <= diff_d[LOCK_W-1:0];
  end

  // shared pin: pulses in lock mode, direction in steer mode
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      lock_or_steer_output_o  <= 1'b0;
      lock_or_steer_output_oe <= 1'b0;
      steer_up                <= 1'b0;
      steer_dn                <= 1'b0;
    end
    else if (steer_mode)
    begin
      lock_or_steer_output_o  <= ~vco_fast;
      lock_or_steer_output_oe <= ~locked;
      steer_up                <= 1'b0;
      steer_dn                <= 1'b0;
    end
    else
    begin
      lock_or_steer_output_o  <= 1'b0;
      lock_or_steer_output_oe <= ~locked & mref_tick;
      steer_up                <= ~locked & ~vco_fast;
      steer_dn                <= ~locked & vco_fast;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs

  logic mux_d;

  // readback multiplexer
  always_comb
  begin
    unique case (mux_sel)
      MUX_LOW:  mux_d = 1'b0;
      MUX_LOOP: mux_d = loop_bit_q;
      MUX_LOCK: mux_d = locked;
      MUX_REF:  mux_d = pin_q[1];
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      mux_out                  <= 1'b0;
      main_ref_tick            <= 1'b0;
      aux_ref_tick             <= 1'b0;
      main_vco_tick            <= 1'b0;
      aux_vco_tick             <= 1'b0;
      main_phase_detector_gain <= '0;
      aux_phase_detector_gain  <= '0;
      main_locked              <= 1'b0;
      power_down               <= '0;
      mod_data                 <= '0;
      main_div_now             <= DIV_OFFSET;
      aux_div_now              <= DIV_OFFSET;
    end
    else
    begin
      mux_out       <= mux_d;
      main_ref_tick <= mref_tick;
      aux_ref_tick  <= aref_tick;
      main_vco_tick <= mtc;
      aux_vco_tick  <= atc;
      main_phase_detector_gain <=
        regs_q[REG_CP_GAIN][GAIN_MAIN_LSB +: GAIN_W];
      aux_phase_detector_gain  <=
        regs_q[REG_CP_GAIN][GAIN_AUX_LSB +: GAIN_W];
      main_locked   <= locked;
      power_down    <= regs_q[REG_PWR][PWR_W-1:0];
      mod_data      <= regs_q[REG_MOD];
      main_div_now  <= main_fi.div_val;
      aux_div_now   <= aux_fi.div_val;
    end
  end

endmodule : synth_ctrl

// ### synth_host.sv
// Purpose: host model driving the serial programming port
// Assumes: each sclk phase lasts 4 ref_clk cycles
// Notes:   echo keeps mux_out seen one cycle into each high phase
`timescale 1ns/1ps
module synth_host (
  // clock
  input  wire logic   ref_clk,
  // serial lines
  output logic        sclk,
  output logic        sdata,
  output logic        cs_n,
  // readback
  input  wire logic   mux_out,
  output logic [31:0] echo
);
  // idle: select high, clock parked low
  initial
  begin
    sclk  = 1'b0;
    sdata = 1'b0;
    cs_n  = 1'b1;
    echo  = 32'h0;
  end

  // msb first, data set while clock low, taken at the rise
  task automatic send(input logic [31:0] w, input int n);
    cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      sclk  <= 1'b0;
      sdata <= w[i];
      repeat (4) @(posedge ref_clk);
      sclk  <= 1'b1;
      @(posedge ref_clk);
      echo  <= {echo[30:0], mux_out}; // bit of the previous fall
      repeat (3) @(posedge ref_clk);
    end
    sclk <= 1'b0;
    repeat (5) @(posedge ref_clk);
    echo  <= {echo[30:0], mux_out};
    cs_n  <= 1'b1;
    sdata <= ~sdata; // released line does not keep its value
    repeat (10) @(posedge ref_clk);
  endtask : send
endmodule : synth_host

// ### synth_ctrl_asserts.sv
// Purpose: port-level checks of the synthesizer control block
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound to every synth_ctrl instance
`timescale 1ns/1ps
module synth_ctrl_asserts
  import synth_pkg::*;
(
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              rstn,
  // serial select
  input wire logic              cs_n,
  // lock pin and steering
  input wire logic              lock_or_steer_output_o,
  input wire logic              lock_or_steer_output_oe,
  input wire logic              steer_up,
  input wire logic              steer_dn,
  input wire logic              main_locked,
  // dividers
  input wire logic              main_ref_tick,
  input wire logic              aux_ref_tick,
  input wire logic [DIVV_W-1:0] main_div_now,
  // settings
  input wire logic [GAIN_W-1:0] main_phase_detector_gain,
  input wire logic [PWR_W-1:0]  power_down,
  input wire logic [WORD_W-1:0] mod_data
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // lock pin behaviour
  chk_locked_pin_off: assert property (main_locked [*3]
    |-> !lock_or_steer_output_oe) else $error("pin driven while locked");
  chk_lock_pulse_low: assert property ((steer_up || steer_dn) [*3]
    ##0 lock_or_steer_output_oe |-> !lock_or_steer_output_o)
    else $error("lock pulse not low");
  chk_steer_one_way: assert property (!(steer_up && steer_dn))
    else $error("steer up and down together");

  // reference ticks never further apart than 32 cycles
  chk_main_ref_gap: assert property (disable iff (!rstn || power_down != 0)
    main_ref_tick |=> ##[0:31] main_ref_tick) else $error("main ref gap");
  chk_aux_ref_gap: assert property (disable iff (!rstn || power_down != 0)
    aux_ref_tick |=> ##[0:31] aux_ref_tick) else $error("aux ref gap");

  // divider values
  chk_reset_div: assert property ($rose(rstn) |->
    main_div_now == 10'h020 && !lock_or_steer_output_oe)
    else $error("bad state after reset");
  chk_div_window: assert property (main_div_now >= 10'h01f
    && main_div_now <= 10'h220) else $error("division out of range");

  // settings change only after a frame closed
  chk_gain_hold: assert property ($changed(main_phase_detector_gain)
    |-> cs_n && $past(cs_n, 3)) else $error("gain changed in frame");
  chk_power_hold: assert property ($changed(power_down)
    |-> cs_n && $past(cs_n, 3)) else $error("power changed in frame");
  chk_mod_hold: assert property ($changed(mod_data)
    |-> cs_n && $past(cs_n, 3)) else $error("mod data changed in frame");
endmodule : synth_ctrl_asserts

bind synth_ctrl synth_ctrl_asserts u_chk (
  .ref_clk(ref_clk), .rstn(rstn), .cs_n(cs_n),
  .lock_or_steer_output_o(lock_or_steer_output_o),
  .lock_or_steer_output_oe(lock_or_steer_output_oe),
  .steer_up(steer_up), .steer_dn(steer_dn), .main_locked(main_locked),
  .main_ref_tick(main_ref_tick), .aux_ref_tick(aux_ref_tick),
  .main_div_now(main_div_now), .power_down(power_down),
  .main_phase_detector_gain(main_phase_detector_gain),
  .mod_data(mod_data));

// ### synth_ctrl_tb.sv
// Purpose: self-checking bench for the synthesizer control block
// Assumes: host model drives the serial port, bench the vco inputs
// Notes:   seeded random data mixed with fixed corner cases
`timescale 1ns/1ps
module synth_ctrl_tb
  import synth_pkg::*;
;
  logic              ref_clk = 1'b0;
  logic              rstn = 1'b0;
  logic              vco_run = 1'b0;
  logic [1:0]        vco_cnt = 2'h0;
  logic              main_vco_in = 1'b0;
  logic              aux_vco_in = 1'b0;
  logic              sclk, sdata, cs_n, mux_out, pin_o, pin_oe;
  logic              steer_up, steer_dn;
  logic [GAIN_W-1:0] gain_m, gain_a;
  logic [PWR_W-1:0]  power_down;
  logic [WORD_W-1:0] mod_data;
  logic [DIVV_W-1:0] div_m, div_a;
  logic [31:0]       echo, r;
  logic [4:0]        rc[3];
  wire               pin = pin_oe ? pin_o : 1'b1;
  int                error_cnt = 0;
  int                n_checks = 0;
  int                cyc = 0;
  int                nb[3] = '{1, 8, 12};
  int                p, hi, bad;

  synth_ctrl dut (.ref_clk(ref_clk), .rstn(rstn), .sclk(sclk),
    .sdata(sdata), .cs_n(cs_n), .mux_out(mux_out),
    .main_vco_in(main_vco_in), .aux_vco_in(aux_vco_in),
    .lock_or_steer_output_i(pin), .lock_or_steer_output_o(pin_o),
    .lock_or_steer_output_oe(pin_oe), .main_ref_tick(),
    .aux_ref_tick(), .main_vco_tick(), .aux_vco_tick(),
    .main_phase_detector_gain(gain_m), .aux_phase_detector_gain(gain_a),
    .steer_up(steer_up), .steer_dn(steer_dn), .main_locked(),
    .power_down(power_down), .mod_data(mod_data),
    .main_div_now(div_m), .aux_div_now(div_a));
  synth_host host (.ref_clk(ref_clk), .sclk(sclk), .sdata(sdata),
    .cs_n(cs_n), .mux_out(mux_out), .echo(echo));

  // 125 MHz clock
  always #4 ref_clk = ~ref_clk;

  // vco stand-in, one rising edge every 4 cycles; hang guard
  always @(posedge ref_clk)
  begin
    vco_cnt     <= vco_cnt + 2'h1;
    main_vco_in <= vco_run & vco_cnt[1];
    aux_vco_in  <= vco_run & vco_cnt[1];
    cyc         <= cyc + 1;
    if (cyc == 60000)
    begin
      error_cnt++;
      conclude();
    end
  end

  function automatic logic [DIVV_W-1:0] exp_div(input logic [8:0] n);
    return {1'b0, n} + DIV_OFFSET;
  endfunction : exp_div

  function automatic logic [31:0] exp_ref(input logic [4:0] c);
    return c + 32'h1;
  endfunction : exp_ref

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [11:0] d);
    host.send({16'h0000, a, d}, 16);
  endtask : wr

  // cycles between the second and third tick of a divider
  task automatic gap(input logic [1:0] s, output int p);
    int k;
    int c;
    k = 0;
    c = 0;
    p = 0;
    for (int i = 0; i < 2000 && k < 3; i++)
    begin
      @(posedge ref_clk);
      c++;
      if ((s == 2'h2 ? dut.main_vco_tick :
           s[0] ? dut.aux_ref_tick : dut.main_ref_tick) === 1'b1)
      begin
        k++;
        p = c;
        c = 0;
      end
    end
  endtask : gap

  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // main sequence
  initial
  begin
    r = $urandom(32'h4bd3720d);
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check(div_m, exp_div(9'h000));
    check({power_down, gain_m, gain_a, mod_data}, 32'h0);
    // lock mode after reset, vco stopped, ref tick every cycle
    hi = 0;
    bad = 0;
    repeat (100)
    begin
      @(posedge ref_clk);
      hi += pin_oe;
      bad += (pin_oe & pin) | steer_dn;
    end
    check(hi > 0, 1);
    check(bad, 0);
    check(steer_up, 1);
    wr(REG_CONFIG, 12'h00d);
    repeat (20) @(posedge ref_clk);
    check({pin_oe, pin}, 2'h3);
    check({steer_up, steer_dn}, 2'h0);
    wr(REG_CONFIG, 12'h03d);
    check(mux_out, 1'b1);
    wr(REG_CONFIG, 12'h02d);
    check({mux_out, dut.main_locked}, 2'h0);
    // gains, power modes, unmapped addresses 10 to 15
    for (int i = 0; i < 6; i++)
    begin
      r = $urandom;
      wr(REG_CP_GAIN, r[11:0]);
      wr(4'ha + i[3:0], ~r[11:0]);
      check({gain_a, gain_m}, r[9:0]);
      wr(REG_PWR, r[23:12]);
      check(power_down, r[15:12]);
    end
    // short frames go to the modulation register
    foreach (nb[k])
    begin
      r = $urandom;
      host.send(r, nb[k]);
      check(mod_data, r & ((32'h1 << nb[k]) - 1));
    end
    r = $urandom;
    host.send({r[7:0], REG_PWR, r[23:12]}, 24);
    check(power_down, r[15:12]);
    wr(REG_PWR, 12'h000);
    // loopback of the received stream
    wr(REG_CONFIG, 12'h015);
    host.send({REG_MOD, r[11:0]}, 16);
    check(echo[15:0], {REG_MOD, r[11:0]});
    check(mod_data, r[11:0]);
    // reference ratios, both ends of the code range
    rc = '{5'h00, 5'h1f, r[4:0]};
    foreach (rc[k])
    begin
      wr(REG_REF_DIV, {2'h0, 5'h1f - rc[k], rc[k]});
      gap(1'b0, p);
      check(p, exp_ref(rc[k]));
      gap(1'b1, p);
      check(p, exp_ref(5'h1f - rc[k]));
    end
    // integer then fractional vco division
    vco_run <= 1'b1;
    wr(REG_CONFIG, 12'h000);
    wr(REG_MAIN_DIV, {6'h00, r[5:0]});
    wr(REG_AUX_DIV, 12'h1ff);
    repeat (5000) @(posedge ref_clk);
    check(div_m, exp_div({3'h0, r[5:0]}));
    check(div_a, exp_div(9'h1ff));
    gap(2'h2, p);
    check(p, 4 * exp_div({3'h0, r[5:0]}));
    wr(REG_CONFIG, 12'h005);
    wr(REG_MAIN_DIV, {6'h00, r[11:6]});
    repeat (1000) @(posedge ref_clk);
    check(div_m, exp_div({3'h0, r[5:0]}));
    wr(REG_MAIN_MSB, 12'h080);
    repeat (1000) @(posedge ref_clk);
    check(div_m - exp_div({3'h0, r[11:6]}) + 1 <= 2, 1);
    conclude();
  end
endmodule : synth_ctrl_tb
